// ===== design/sidio_pkg.sv
// Package: register map, status bit layout and bus carrier types for the status/digital I/O block
package sidio_pkg;

  // ****************************************
  // Register offsets (second base window)
  // ****************************************
  localparam logic [11:0] SIDIO_OFS_P8_DIR  = 12'h400;
  localparam logic [11:0] SIDIO_OFS_P8_DAT  = 12'h410;
  localparam logic [11:0] SIDIO_OFS_P10_DIR = 12'h420;
  localparam logic [11:0] SIDIO_OFS_P10_DAT = 12'h430;
  localparam logic [11:0] SIDIO_OFS_STATUS  = 12'h500;

  // ****************************************
  // Status register bit positions
  // ****************************************
  localparam int SIDIO_B_GIE      = 0;
  localparam int SIDIO_B_ADC_EMP  = 1;
  localparam int SIDIO_B_LIST_DN  = 2;
  localparam int SIDIO_B_ADC_IRQ  = 3;
  localparam int SIDIO_B_LIST_IRQ = 4;
  localparam int SIDIO_B_O0_EMP   = 5;
  localparam int SIDIO_B_O0_HALF  = 6;
  localparam int SIDIO_B_O0_DIRQ  = 7;
  localparam int SIDIO_B_O0_HIRQ  = 8;
  localparam int SIDIO_B_O1_EMP   = 9;
  localparam int SIDIO_B_O1_HALF  = 10;
  localparam int SIDIO_B_O1_DIRQ  = 11;
  localparam int SIDIO_B_O1_HIRQ  = 12;
  localparam int SIDIO_B_TMR0     = 13;
  localparam int SIDIO_B_SER_LO   = 16;
  localparam int SIDIO_SER_W      = 8;
  localparam int SIDIO_STAT_W     = 24;
  localparam int SIDIO_P8_W       = 8;
  localparam int SIDIO_P10_W      = 10;

  // Sticky bits cleared by writing zero
  localparam logic [23:0] SIDIO_STICKY_MASK = 24'h00F98C;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [23:0] SIDIO_STAT_RST = 24'h000000;
  localparam logic [7:0]  SIDIO_P8_RST   = 8'h00;
  localparam logic [9:0]  SIDIO_P10_RST  = 10'h000;

  // Host register access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sidio_req_s;

  // Engine status levels
  typedef struct packed {
    logic adc_empty;
    logic o0_empty;
    logic o0_half;
    logic o1_empty;
    logic o1_half;
  } sidio_fifo_s;

  // Engine events and per-source enables
  typedef struct packed {
    logic       list_done;
    logic [2:0] timer_tc;
    logic       adc_fill_en;
    logic       list_en;
    logic       o0_drain_en;
    logic       o0_half_en;
    logic       o1_drain_en;
    logic       o1_half_en;
    logic [2:0] timer_en;
  } sidio_evt_s;

endpackage

// ===== design/sidio_regs.sv
// Module: global status register, sticky event bits and two bidirectional I/O ports
`timescale 1ns/100ps

module sidio_regs (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire sidio_pkg::sidio_req_s         req,
  output logic     [31:0]                    rdata,
  output logic                               rvalid,
  input  wire sidio_pkg::sidio_fifo_s        fifo,
  input  wire sidio_pkg::sidio_evt_s         evt,
  output logic                               pci_inta,
  output logic                               cfg_mem_serial_clock,
  output logic                               cfg_mem_chip_select,
  output logic                               cfg_mem_data_in,
  output logic                               cfg_mem_data_out,
  output logic                               trim_conv_serial_clock,
  output logic                               trim_conv1_load,
  output logic                               trim_conv2_load,
  output logic                               trim_conv_serial_data,
  input  wire logic [7:0]                    general_io_pins_in,
  output logic      [7:0]                    general_io_pins_out,
  output logic      [7:0]                    general_io_pins_oe,
  input  wire logic [9:0]                    multifunction_io_pins_in,
  output logic      [9:0]                    multifunction_io_pins_out,
  output logic      [9:0]                    multifunction_io_pins_oe
);
  import sidio_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  logic [SIDIO_STAT_W-1:0] stat_r;
  logic [SIDIO_STAT_W-1:0] stat_nxt;
  logic [SIDIO_STAT_W-1:0] stat_view;
  logic [SIDIO_P8_W-1:0]   p8_dir_r;
  logic [SIDIO_P8_W-1:0]   p8_dat_r;
  logic [SIDIO_P10_W-1:0]  p10_dir_r;
  logic [SIDIO_P10_W-1:0]  p10_dat_r;
  sidio_fifo_s             fifo_prev_r;
  logic [31:0]             rdata_nxt;

  wire sel_stat    = req.addr == SIDIO_OFS_STATUS;
  wire sel_p8_dir  = req.addr == SIDIO_OFS_P8_DIR;
  wire sel_p8_dat  = req.addr == SIDIO_OFS_P8_DAT;
  wire sel_p10_dir = req.addr == SIDIO_OFS_P10_DIR;
  wire sel_p10_dat = req.addr == SIDIO_OFS_P10_DAT;
  wire wr_stat     = req.wr & sel_stat;

  // ****************************************
  // Event detection
  // ****************************************
  // Sticky set terms, placed at their status bit positions
  logic [SIDIO_STAT_W-1:0] set_vec;
  always_comb begin
    set_vec = '0;
    set_vec[SIDIO_B_LIST_DN] = evt.list_done;
    set_vec[SIDIO_B_ADC_IRQ] = evt.adc_fill_en & fifo_prev_r.adc_empty & ~fifo.adc_empty;
    set_vec[SIDIO_B_O0_DIRQ] = evt.o0_drain_en & ~fifo_prev_r.o0_empty & fifo.o0_empty;
    set_vec[SIDIO_B_O1_DIRQ] = evt.o1_drain_en & ~fifo_prev_r.o1_empty & fifo.o1_empty;
    set_vec[SIDIO_B_O0_HIRQ] = evt.o0_half_en & fifo_prev_r.o0_half & ~fifo.o0_half;
    set_vec[SIDIO_B_O1_HIRQ] = evt.o1_half_en & fifo_prev_r.o1_half & ~fifo.o1_half;
  end

  logic [2:0] tmr_set;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tmr
      assign tmr_set[gi] = evt.timer_tc[gi] & evt.timer_en[gi];
    end
  endgenerate

  // ****************************************
  // Status register next state
  // ****************************************
  // Sticky bits: write zero clears, write one keeps, a set in the same cycle wins
  wire [SIDIO_STAT_W-1:0] set_all   = set_vec | {8'h00, tmr_set, 13'h0000};
  wire [SIDIO_STAT_W-1:0] clr_all   = wr_stat ? (SIDIO_STICKY_MASK & ~req.wdata[SIDIO_STAT_W-1:0])
                                              : 24'h000000;
  // Software-owned bits: enable and the eight serial lines
  wire [SIDIO_STAT_W-1:0] sw_mask   = 24'hFF0001;
  always_comb begin
    stat_nxt = stat_r;
    stat_nxt = ((stat_r & ~clr_all) | set_all) & SIDIO_STICKY_MASK | (stat_r & ~SIDIO_STICKY_MASK);
    if (wr_stat) begin
      stat_nxt = (stat_nxt & ~sw_mask) | (req.wdata[SIDIO_STAT_W-1:0] & sw_mask);
    end
  end

  // Live view: read-only status levels and the derived list interrupt
  always_comb begin
    stat_view = stat_r;
    stat_view[SIDIO_B_ADC_EMP]  = fifo.adc_empty;
    stat_view[SIDIO_B_O0_EMP]   = fifo.o0_empty;
    stat_view[SIDIO_B_O0_HALF]  = fifo.o0_half;
    stat_view[SIDIO_B_O1_EMP]   = fifo.o1_empty;
    stat_view[SIDIO_B_O1_HALF]  = fifo.o1_half;
    stat_view[SIDIO_B_LIST_IRQ] = stat_r[SIDIO_B_LIST_DN] & evt.list_en;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_r      <= SIDIO_STAT_RST;
      fifo_prev_r <= '0;
    end else begin
      stat_r      <= stat_nxt;
      fifo_prev_r <= fifo;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      p8_dir_r <= SIDIO_P8_RST;
      p8_dat_r <= SIDIO_P8_RST;
    end else begin
      if (req.wr & sel_p8_dir) p8_dir_r <= req.wdata[SIDIO_P8_W-1:0];
      if (req.wr & sel_p8_dat) p8_dat_r <= req.wdata[SIDIO_P8_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      p10_dir_r <= SIDIO_P10_RST;
      p10_dat_r <= SIDIO_P10_RST;
    end else begin
      if (req.wr & sel_p10_dir) p10_dir_r <= req.wdata[SIDIO_P10_W-1:0];
      if (req.wr & sel_p10_dat) p10_dat_r <= req.wdata[SIDIO_P10_W-1:0];
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Direction registers read as zero
  assign rdata_nxt = sel_stat   ? {8'h00, stat_view}
                   : sel_p8_dat  ? {24'h000000, general_io_pins_in}
                   : sel_p10_dat ? {22'h000000, multifunction_io_pins_in}
                   : 32'h00000000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata  <= 32'h00000000;
      rvalid <= 1'b0;
    end else begin
      rdata  <= req.rd ? rdata_nxt : 32'h00000000;
      rvalid <= req.rd;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Any sticky bit except list done, or the list interrupt bit, raises the line
  wire any_pending = |(stat_view & (SIDIO_STICKY_MASK | 24'h000010) & ~24'h000004);
  assign pci_inta = stat_r[SIDIO_B_GIE] & any_pending;

  assign cfg_mem_serial_clock   = stat_r[SIDIO_B_SER_LO];
  assign cfg_mem_chip_select    = stat_r[SIDIO_B_SER_LO+1];
  assign cfg_mem_data_in        = stat_r[SIDIO_B_SER_LO+2];
  assign cfg_mem_data_out       = stat_r[SIDIO_B_SER_LO+3];
  assign trim_conv_serial_clock = stat_r[SIDIO_B_SER_LO+4];
  assign trim_conv1_load        = stat_r[SIDIO_B_SER_LO+5];
  assign trim_conv2_load        = stat_r[SIDIO_B_SER_LO+6];
  assign trim_conv_serial_data  = stat_r[SIDIO_B_SER_LO+7];

  // Drive only pins set as outputs
  assign general_io_pins_out       = p8_dat_r;
  assign general_io_pins_oe        = p8_dir_r;
  // Convert pin relies on software direction
  assign multifunction_io_pins_out = p10_dat_r;
  assign multifunction_io_pins_oe  = p10_dir_r;

endmodule

// ===== verification/sidio_chk.sv
// Checker: port-level properties of the status and digital I/O registers
`timescale 1ns/100ps
module sidio_chk (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire sidio_pkg::sidio_req_s  req,
  input wire logic [31:0]            rdata,
  input wire logic                   rvalid,
  input wire sidio_pkg::sidio_fifo_s fifo,
  input wire sidio_pkg::sidio_evt_s  evt,
  input wire logic                   pci_inta,
  input wire logic [7:0]             general_io_pins_in,
  input wire logic [7:0]             general_io_pins_oe,
  input wire logic [9:0]             multifunction_io_pins_oe
);
  import sidio_pkg::*;
  logic gie_r;
  wire  st_w = req.wr && req.addr == SIDIO_OFS_STATUS;
  wire  st_r = req.rd && req.addr == SIDIO_OFS_STATUS;
  // Enable shadow built from host writes only, never from the block
  always_ff @(posedge clock or posedge rst)
    if (rst)
      gie_r <= 1'b0;
    else if (st_w)
      gie_r <= req.wdata[0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ******
  // Properties
  // ******
  a_inta_gated: assert property (!gie_r |-> !pci_inta) else $error("line raised while disabled");
  a_levels_seen: assert property (st_r |=> rdata[1] == $past(fifo.adc_empty)
    && rdata[6:5] == {$past(fifo.o0_half), $past(fifo.o0_empty)}
    && rdata[10:9] == {$past(fifo.o1_half), $past(fifo.o1_empty)}) else $error("level bits wrong");
  a_dir_hidden: assert property (req.rd && (req.addr == SIDIO_OFS_P8_DIR || req.addr == SIDIO_OFS_P10_DIR)
    |=> rvalid && rdata == 32'h0) else $error("direction reads back");
  a_p8_pins: assert property (req.rd && req.addr == SIDIO_OFS_P8_DAT
    |=> rvalid && rdata == {24'h0, $past(general_io_pins_in)}) else $error("port8 read wrong");
  a_p8_dir: assert property (req.wr && req.addr == SIDIO_OFS_P8_DIR
    |=> general_io_pins_oe == $past(req.wdata[7:0])) else $error("port8 direction wrong");
  a_p10_dir: assert property (req.wr && req.addr == SIDIO_OFS_P10_DIR
    |=> multifunction_io_pins_oe == $past(req.wdata[9:0])) else $error("port10 direction wrong");
  a_timer_fires: assert property (gie_r && !st_w && evt.timer_tc[1] && evt.timer_en[1]
    |=> pci_inta) else $error("timer expiry missed");
  a_plain_keep: assert property (st_w ##1 !st_w ##1 st_r
    |=> rdata[23:16] == $past(req.wdata[23:16], 3)) else $error("pin bits not kept");
endmodule

// ===== verification/sidio_pins.sv
// Partner: outside world on a bidirectional port
`timescale 1ns/100ps
module sidio_pins #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] drv_out,
  input  wire logic [W-1:0] drv_oe,
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] pin
);
  // Outside drives only released pins, so no contention is modelled
  assign pin = (drv_out & drv_oe) | (ext & ~drv_oe);
endmodule

// ===== verification/tb.sv
// Testbench: bench model and scenarios for the status and digital I/O registers
`timescale 1ns/100ps
module tb;
  import sidio_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  sidio_req_s  req = '0;
  sidio_fifo_s fifo = '0;
  sidio_evt_s  evt = '0;
  logic [31:0] rdata;
  logic [31:0] seed = 32'h0001499B;
  logic        rvalid, pci_inta;
  wire  [7:0]  ser;
  logic [7:0]  p8i, p8o, p8e;
  logic [9:0]  p10i, p10o, p10e;
  logic [7:0]  x8 = 8'h00;
  logic [9:0]  x10 = 10'h000;
  int          bad_count = 0, tests_run = 0, stick = 0, plain = 0, d8, e8, d10, e10;
  always #10 clock = ~clock;
  sidio_regs u_dut (.clock, .rst, .req, .rdata, .rvalid, .fifo, .evt, .pci_inta,
    .cfg_mem_serial_clock(ser[0]), .cfg_mem_chip_select(ser[1]), .cfg_mem_data_in(ser[2]),
    .cfg_mem_data_out(ser[3]), .trim_conv_serial_clock(ser[4]), .trim_conv1_load(ser[5]),
    .trim_conv2_load(ser[6]), .trim_conv_serial_data(ser[7]), .general_io_pins_in(p8i),
    .general_io_pins_out(p8o), .general_io_pins_oe(p8e), .multifunction_io_pins_in(p10i),
    .multifunction_io_pins_out(p10o), .multifunction_io_pins_oe(p10e));
  sidio_pins #(.W(8)) u_p8 (.drv_out(p8o), .drv_oe(p8e), .ext(x8), .pin(p8i));
  sidio_pins #(.W(10)) u_p10 (.drv_out(p10o), .drv_oe(p10e), .ext(x10), .pin(p10i));
  // ******
  // Model and bus tasks
  // ******
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] stat();
    return plain | stick | fifo.adc_empty << 1 | fifo.o0_empty << 5 | fifo.o0_half << 6
      | fifo.o1_empty << 9 | fifo.o1_half << 10 | (stick[2] & evt.list_en) << 4;
  endfunction
  function automatic logic irq();
    return plain[0] && (stat() & 32'hF998) != 0;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clock);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clock);
    req.wr = 1'b0;
    case (a)
      SIDIO_OFS_STATUS: stick = stick & d;
      SIDIO_OFS_P8_DIR: e8 = d[7:0];
      SIDIO_OFS_P8_DAT: d8 = d[7:0];
      SIDIO_OFS_P10_DIR: e10 = d[9:0];
      SIDIO_OFS_P10_DAT: d10 = d[9:0];
      default: ;
    endcase
    if (a == SIDIO_OFS_STATUS)
      plain = d & 32'hFF0001;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge clock);
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clock);
    #1;
    check({31'h0, rvalid}, 32'h1);
    check(rdata, e);
    @(negedge clock);
    req.rd = 1'b0;
  endtask
  task automatic pulse(input int b);
    @(negedge clock);
    evt[b] = 1'b1;
    @(negedge clock);
    evt[b] = 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Test sequence takes under two hundred cycles; the 2500-cycle limit is ample
  initial begin
    #50000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    check({14'h0, p8e, p10e}, 32'h0);
    rd(SIDIO_OFS_STATUS, stat());
    rd(SIDIO_OFS_P8_DIR, 32'h0);
    rd(SIDIO_OFS_P10_DIR, 32'h0);
    rd(12'h7FC, 32'h0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      x8 = seed[7:0];
      x10 = seed[17:8];
      wr(SIDIO_OFS_P8_DIR, seed[31:24]);
      wr(SIDIO_OFS_P8_DAT, seed[23:16]);
      wr(SIDIO_OFS_P10_DIR, seed[25:16] & 10'h3FB);
      wr(SIDIO_OFS_P10_DAT, seed[31:22]);
      check({16'h0, p8o, p8e}, {16'h0, d8[7:0], e8[7:0]});
      check({12'h0, p10o, p10e}, {12'h0, d10[9:0], e10[9:0]});
      rd(SIDIO_OFS_P8_DAT, d8 & e8 | x8 & ~e8);
      rd(SIDIO_OFS_P10_DAT, d10 & e10 | x10 & ~e10);
    end
    seed = lfsr(seed);
    wr(SIDIO_OFS_STATUS, seed & 32'hFF0000);
    check({24'h0, ser}, plain >> 16);
    rd(SIDIO_OFS_STATUS, stat());
    wr(SIDIO_OFS_STATUS, plain | 1);
    evt.timer_en = 3'b011;
    for (int i = 0; i < 3; i++) begin
      pulse(9 + i);
      stick = stick | evt.timer_en[i] << (13 + i);
      rd(SIDIO_OFS_STATUS, stat());
      check({31'h0, pci_inta}, {31'h0, irq()});
      wr(SIDIO_OFS_STATUS, plain | stick & ~(1 << (13 + i)));
      rd(SIDIO_OFS_STATUS, stat());
    end
    fork
      wr(SIDIO_OFS_STATUS, plain);
      pulse(9);
    join
    stick = stick | 32'h2000;
    rd(SIDIO_OFS_STATUS, stat());
    for (int p = 0; p < 2; p++) begin
      evt[8:3] = p ? 6'h3F : 6'h00;
      fifo = 5'b10101;
      repeat (2) @(negedge clock);
      rd(SIDIO_OFS_STATUS, stat());
      fifo = 5'b01010;
      repeat (2) @(negedge clock);
      stick = stick | (p ? 32'h1988 : 32'h0);
      rd(SIDIO_OFS_STATUS, stat());
      check({31'h0, pci_inta}, {31'h0, irq()});
      wr(SIDIO_OFS_STATUS, plain);
    end
    evt.list_en = 1'b0;
    pulse(12);
    stick = stick | 4;
    rd(SIDIO_OFS_STATUS, stat());
    check({31'h0, pci_inta}, 32'h0);
    evt.list_en = 1'b1;
    rd(SIDIO_OFS_STATUS, stat());
    check({31'h0, pci_inta}, {31'h0, irq()});
    wr(SIDIO_OFS_STATUS, plain & ~1 | 4);
    check({31'h0, pci_inta}, 32'h0);
    rd(SIDIO_OFS_STATUS, stat());
    evt.list_en = 1'b0;
    rd(SIDIO_OFS_STATUS, stat());
    wr(SIDIO_OFS_STATUS, plain);
    rd(SIDIO_OFS_STATUS, stat());
    complete_run();
  end
endmodule
bind sidio_regs sidio_chk u_chk (.clock, .rst, .req, .rdata, .rvalid, .fifo, .evt, .pci_inta,
  .general_io_pins_in, .general_io_pins_oe, .multifunction_io_pins_oe);
